/* File: core/ufx_top.sv */
`timescale 1ns/10ps
module ufx_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [5:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        serial_in_pin_in,
  output logic             serial_out_pin_out,
  output logic             tx_done_irq_out,
  output logic             rx_done_irq_out,
  output logic             tx_drained_irq_out
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [6:0]  ctrl0_q, ctrl0_d;
  logic [2:0]  fctl_q, fctl_d;
  logic [7:0]  trig_q, trig_d;
  logic [15:0] div_q, div_d;
  logic [2:0]  err_q, err_d;
  logic [31:0] rdata_d;
  logic        tx_flush;
  logic        rx_flush;
  logic        tx_en;
  logic        rx_en;
  logic        fifo_sel;
  ufx_pkg::ufx_frame_cfg_s cfg;

  logic [7:0]  tx_mem [16];
  logic [3:0]  tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [4:0]  tx_cnt_q, tx_cnt_d, tx_cap, tx_free;
  logic        tx_push, tx_load, tx_end, tx_busy;
  ufx_pkg::ufx_tx_state_e tx_st_q, tx_st_d;
  logic [11:0] tx_frm_q, tx_frm_d;
  logic [3:0]  tx_left_q, tx_left_d;
  logic [15:0] tx_baud_q, tx_baud_d;
  logic        tx_pin_d, drained_d;

  ufx_pkg::ufx_rx_word_s rx_mem [16];
  logic [3:0]  rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [4:0]  rx_cnt_q, rx_cnt_d, rx_cap;
  logic        rx_push, rx_pop, rx_ovr;
  ufx_pkg::ufx_rx_state_e rx_st_q, rx_st_d;
  logic [10:0] rx_sh_q, rx_sh_d;
  logic [3:0]  rx_left_q, rx_left_d;
  logic [15:0] rx_baud_q, rx_baud_d;
  logic        rx_prev_q;
  logic        rx_valid_q, rx_valid_d;
  ufx_pkg::ufx_rx_word_s rx_word_q, rx_word_d;

  logic [3:0]  nchar;
  logic [3:0]  nbits;

  assign tx_en    = ctrl0_q[ufx_pkg::CTRL0_TXEN];
  assign rx_en    = ctrl0_q[ufx_pkg::CTRL0_RXEN];
  assign cfg      = ufx_pkg::ufx_frame_cfg_s'(ctrl0_q[6:ufx_pkg::CTRL0_CFG_LSB]); // R8
  assign fifo_sel = fctl_q[ufx_pkg::FCTL_SEL];
  assign nchar    = cfg.char7 ? 4'h7 : 4'h8;
  assign nbits    = nchar + ((cfg.parity != ufx_pkg::PAR_NONE) ? 4'h1 : 4'h0);
  assign tx_cap   = fifo_sel ? ufx_pkg::FIFO_DEPTH : 5'h01;
  assign rx_cap   = fifo_sel ? ufx_pkg::FIFO_DEPTH : 5'h01;
  assign tx_free  = tx_cap - tx_cnt_q; // R4
  assign tx_busy  = (tx_st_q == ufx_pkg::UFX_TX_SHIFT) || (tx_cnt_q != 5'h00); // R22

  // Parity over the character bits actually sent
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode,
                                   input logic c7);
    logic p;
    p = ^(c7 ? {1'b0, d[6:0]} : d);
    unique case (mode)
      ufx_pkg::PAR_ODD:  par_bit = ~p;
      ufx_pkg::PAR_EVEN: par_bit = p;
      default:           par_bit = 1'b0;
    endcase
  endfunction

  // Bit order swap within the active character length
  function automatic logic [7:0] order(input logic [7:0] d, input logic msb,
                                       input logic c7);
    logic [7:0] r;
    r = d;
    if (msb) begin
      r = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
      if (c7) begin
        r = {1'b0, r[7:1]};
      end
    end
    order = r;
  endfunction

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  always_comb begin
    ctrl0_d  = ctrl0_q;
    fctl_d   = fctl_q;
    trig_d   = trig_q;
    div_d    = div_q;
    tx_flush = 1'b0;
    rx_flush = 1'b0;
    err_d    = err_q;
    rdata_d  = 32'h0000_0000;
    if (wr_in) begin
      case (addr_in)
        ufx_pkg::A_CTRL0:  ctrl0_d = wdata_in[6:0];
        ufx_pkg::A_FCTL: begin
          fctl_d   = wdata_in[2:0];
          tx_flush = wdata_in[ufx_pkg::FCTL_TXFLUSH]; // R19
          rx_flush = wdata_in[ufx_pkg::FCTL_RXFLUSH];
        end
        ufx_pkg::A_TRIG:   trig_d = wdata_in[7:0];
        ufx_pkg::A_DIV:    div_d = wdata_in[15:0];
        ufx_pkg::A_STATUS: err_d = err_q & ~wdata_in[3:1];
        default: ;
      endcase
    end
    err_d = err_d | {rx_ovr, rx_valid_q & rx_word_q.ferr, rx_valid_q & rx_word_q.perr};
    if (rd_in) begin
      case (addr_in)
        ufx_pkg::A_CTRL0:  rdata_d[6:0] = ctrl0_q;
        ufx_pkg::A_FCTL:   rdata_d[2:0] = fctl_q;
        ufx_pkg::A_TRIG:   rdata_d[7:0] = trig_q;
        ufx_pkg::A_DIV:    rdata_d[15:0] = div_q;
        ufx_pkg::A_RXDATA: rdata_d[9:0] = (rx_cnt_q != 5'h00) ? rx_mem[rx_rp_q] : 10'h000;
        ufx_pkg::A_STATUS: rdata_d[3:0] = {err_q, tx_busy};
        ufx_pkg::A_TXFREE: rdata_d[4:0] = tx_free; // R4
        ufx_pkg::A_RXFILL: rdata_d[4:0] = rx_cnt_q; // R7
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl0_q   <= ufx_pkg::CTRL0_RST;
      fctl_q    <= ufx_pkg::FCTL_RST;
      trig_q    <= ufx_pkg::TRIG_RST;
      div_q     <= ufx_pkg::DIV_RST;
      err_q     <= 3'h0;
      rdata_out <= 32'h0000_0000;
    end else begin
      ctrl0_q   <= ctrl0_d;
      fctl_q    <= fctl_d;
      trig_q    <= trig_d;
      div_q     <= div_d;
      err_q     <= err_d;
      rdata_out <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Transmit FIFO and shifter
  // ---------------------------------------------------------------
  assign tx_push = wr_in && (addr_in == ufx_pkg::A_TXDATA) && (tx_cnt_q < tx_cap);
  // Enable gates every load, so FIFO mode starts only once enabled
  assign tx_load = (tx_st_q == ufx_pkg::UFX_TX_IDLE) && tx_en && (tx_cnt_q != 5'h00)
                   && !tx_flush; // R10 R11 R20
  assign tx_end  = (tx_st_q == ufx_pkg::UFX_TX_SHIFT) && (tx_baud_q == 16'h0000)
                   && (tx_left_q == 4'h0);

  always_comb begin
    logic [7:0] d;
    d         = order(tx_mem[tx_rp_q], cfg.msb_first, cfg.char7); // R9
    tx_wp_d   = tx_wp_q + {3'h0, tx_push};
    tx_rp_d   = tx_rp_q + {3'h0, tx_load};
    tx_cnt_d  = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_load};
    tx_st_d   = tx_st_q;
    tx_frm_d  = tx_frm_q;
    tx_left_d = tx_left_q;
    tx_baud_d = tx_baud_q;
    tx_pin_d  = serial_out_pin_out;
    drained_d = 1'b0;
    if (tx_flush) begin
      tx_wp_d  = 4'h0;
      tx_rp_d  = 4'h0;
      tx_cnt_d = 5'h00; // R21
    end
    unique case (tx_st_q)
      ufx_pkg::UFX_TX_IDLE: begin
        tx_pin_d = 1'b1;
        if (tx_load) begin
          tx_frm_d = 12'hFFF; // R13
          tx_frm_d[0] = 1'b0;
          tx_frm_d[8:1] = d;
          if (cfg.char7) begin
            tx_frm_d[8] = 1'b1;
          end
          if (cfg.parity != ufx_pkg::PAR_NONE) begin
            tx_frm_d[nchar + 4'h1] = par_bit(tx_mem[tx_rp_q], cfg.parity, cfg.char7);
          end
          tx_left_d = nbits + (cfg.two_stop ? 4'h2 : 4'h1);
          tx_baud_d = div_q;
          tx_pin_d  = 1'b0;
          tx_st_d   = ufx_pkg::UFX_TX_SHIFT;
        end
      end
      ufx_pkg::UFX_TX_SHIFT: begin
        if (tx_baud_q != 16'h0000) begin
          tx_baud_d = tx_baud_q - 16'h0001;
        end else if (tx_end) begin
          tx_st_d   = ufx_pkg::UFX_TX_IDLE;
          tx_pin_d  = 1'b1;
          drained_d = fifo_sel && (tx_cnt_q == 5'h00); // R18
        end else begin
          tx_frm_d  = {1'b1, tx_frm_q[11:1]};
          tx_pin_d  = tx_frm_q[1];
          tx_left_d = tx_left_q - 4'h1;
          tx_baud_d = div_q;
        end
      end
      default: tx_st_d = ufx_pkg::UFX_TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_wp_q            <= 4'h0;
      tx_rp_q            <= 4'h0;
      tx_cnt_q           <= 5'h00;
      tx_st_q            <= ufx_pkg::UFX_TX_IDLE;
      tx_frm_q           <= 12'hFFF;
      tx_left_q          <= 4'h0;
      tx_baud_q          <= 16'h0000;
      serial_out_pin_out <= 1'b1;
      tx_drained_irq_out <= 1'b0; // R21
    end else begin
      tx_wp_q            <= tx_wp_d;
      tx_rp_q            <= tx_rp_d;
      tx_cnt_q           <= tx_cnt_d;
      tx_st_q            <= tx_st_d;
      tx_frm_q           <= tx_frm_d;
      tx_left_q          <= tx_left_d;
      tx_baud_q          <= tx_baud_d;
      serial_out_pin_out <= tx_pin_d;
      tx_drained_irq_out <= drained_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (tx_push && !tx_flush) begin
      tx_mem[tx_wp_q] <= wdata_in[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Receiver and receive FIFO
  // ---------------------------------------------------------------
  assign rx_push = rx_valid_q && rx_en && (rx_cnt_q < rx_cap) && !rx_flush;
  assign rx_ovr  = rx_valid_q && rx_en && (rx_cnt_q >= rx_cap);
  assign rx_pop  = rd_in && (addr_in == ufx_pkg::A_RXDATA) && (rx_cnt_q != 5'h00);

  always_comb begin
    logic [10:0] al;
    logic [7:0]  raw;
    al         = 11'h000;
    raw        = 8'h00;
    rx_st_d    = rx_st_q;
    rx_sh_d    = rx_sh_q;
    rx_left_d  = rx_left_q;
    rx_baud_d  = rx_baud_q;
    rx_valid_d = 1'b0;
    rx_word_d  = rx_word_q;
    rx_wp_d    = rx_wp_q + {3'h0, rx_push};
    rx_rp_d    = rx_rp_q + {3'h0, rx_pop};
    rx_cnt_d   = rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    if (rx_flush) begin
      rx_wp_d  = 4'h0;
      rx_rp_d  = 4'h0;
      rx_cnt_d = 5'h00;
    end
    unique case (rx_st_q)
      ufx_pkg::UFX_RX_IDLE: begin
        if (rx_en && rx_prev_q && !serial_in_pin_in) begin
          rx_baud_d = {1'b0, div_q[15:1]};
          rx_st_d   = ufx_pkg::UFX_RX_START;
        end
      end
      ufx_pkg::UFX_RX_START: begin
        if (rx_baud_q != 16'h0000) begin
          rx_baud_d = rx_baud_q - 16'h0001;
        end else if (serial_in_pin_in) begin
          rx_st_d = ufx_pkg::UFX_RX_IDLE;
        end else begin
          rx_baud_d = div_q;
          rx_left_d = nbits + 4'h1;
          rx_st_d   = ufx_pkg::UFX_RX_BITS;
        end
      end
      ufx_pkg::UFX_RX_BITS: begin
        if (rx_baud_q != 16'h0000) begin
          rx_baud_d = rx_baud_q - 16'h0001;
        end else begin
          rx_sh_d   = {serial_in_pin_in, rx_sh_q[10:1]};
          rx_left_d = rx_left_q - 4'h1;
          rx_baud_d = div_q;
          if (rx_left_q == 4'h1) begin
            al  = rx_sh_d >> (4'hB - nbits - 4'h1);
            raw = cfg.char7 ? {1'b0, al[6:0]} : al[7:0];
            rx_word_d.data = order(raw, cfg.msb_first, cfg.char7); // R9
            rx_word_d.perr = (cfg.parity != ufx_pkg::PAR_NONE)
                             && (al[nchar] != par_bit(rx_word_d.data, cfg.parity, cfg.char7));
            rx_word_d.ferr = !al[nbits];
            rx_valid_d     = rx_en;
            rx_st_d        = ufx_pkg::UFX_RX_IDLE;
          end
        end
      end
      default: rx_st_d = ufx_pkg::UFX_RX_IDLE;
    endcase
    if (!rx_en) begin
      rx_st_d = ufx_pkg::UFX_RX_IDLE;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_wp_q    <= 4'h0;
      rx_rp_q    <= 4'h0;
      rx_cnt_q   <= 5'h00;
      rx_st_q    <= ufx_pkg::UFX_RX_IDLE;
      rx_sh_q    <= 11'h000;
      rx_left_q  <= 4'h0;
      rx_baud_q  <= 16'h0000;
      rx_prev_q  <= 1'b1;
      rx_valid_q <= 1'b0;
      rx_word_q  <= '0;
    end else begin
      rx_wp_q    <= rx_wp_d;
      rx_rp_q    <= rx_rp_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_st_q    <= rx_st_d;
      rx_sh_q    <= rx_sh_d;
      rx_left_q  <= rx_left_d;
      rx_baud_q  <= rx_baud_d;
      rx_prev_q  <= serial_in_pin_in;
      rx_valid_q <= rx_valid_d;
      rx_word_q  <= rx_word_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= rx_word_q;
    end
  end

  // ---------------------------------------------------------------
  // Completion event policy
  // ---------------------------------------------------------------
  ufx_irq_gate u_tx_gate (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .flush_in   (tx_flush),
    .pointer_in (!fifo_sel || fctl_q[ufx_pkg::FCTL_TXPOL]),
    .trig_in    ({1'b0, trig_q[3:0]} + 5'h01),
    .event_in   (tx_load),
    .credit_in  (tx_push),
    .fire_out   (tx_done_irq_out)
  ); // R14 R15

  ufx_irq_gate u_rx_gate (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .flush_in   (rx_flush),
    .pointer_in (!fifo_sel || fctl_q[ufx_pkg::FCTL_RXPOL]),
    .trig_in    ({1'b0, trig_q[7:4]} + 5'h01),
    .event_in   (rx_push),
    .credit_in  (rx_pop),
    .fire_out   (rx_done_irq_out)
  ); // R5

endmodule

/* File: core/ufx_pkg.sv */
// Operation
// R1: Pointer mode: tx-done on every FIFO load
// R2: Pointer mode needs one-byte transmit trigger
// R3: Pointer mode forbids DMA FIFO transfers
// R4: Report free transmit FIFO bytes
// R5: Pointer mode: rx-done on every FIFO store
// R6: Pointer mode needs one-byte receive trigger
// R7: Rx-done may come with zero fill
// R8: Full-duplex frames with configurable format
// R9: Selectable LSB-first or MSB-first order
// R10: Single mode sends on holding write
// R11: FIFO mode sends once enabled after loading
// R12: Load FIFO before setting transmit enable
// R13: Shift out start, data, parity, stop
// R14: Single mode: tx-done on holding handover
// R15: FIFO mode: tx-done after trigger loads
// R16: Pending mode holds tx-done until refill
// R17: Pointer mode never holds tx-done
// R18: FIFO mode: drained event when all empty
// R19: Flush discards held tx-done events
// R20: Pause transmission while no data
// R21: No events from reset emptying
// R22: Check busy flag before reinitialising
package ufx_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20000000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam logic [15:0] DIV_RST      = 16'(CLK_HZ / BAUD_DEFAULT - 1);

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [5:0] A_CTRL0  = 6'h00;
  localparam logic [5:0] A_FCTL   = 6'h04;
  localparam logic [5:0] A_TRIG   = 6'h08;
  localparam logic [5:0] A_DIV    = 6'h0C;
  localparam logic [5:0] A_TXDATA = 6'h10;
  localparam logic [5:0] A_RXDATA = 6'h14;
  localparam logic [5:0] A_STATUS = 6'h18;
  localparam logic [5:0] A_TXFREE = 6'h1C;
  localparam logic [5:0] A_RXFILL = 6'h20;

  localparam int CTRL0_TXEN    = 0;
  localparam int CTRL0_RXEN    = 1;
  localparam int CTRL0_CFG_LSB = 2;
  localparam int FCTL_SEL      = 0;
  localparam int FCTL_TXPOL    = 1;
  localparam int FCTL_RXPOL    = 2;
  localparam int FCTL_TXFLUSH  = 3;
  localparam int FCTL_RXFLUSH  = 4;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_PERR     = 1;
  localparam int STAT_FERR     = 2;
  localparam int STAT_OVR      = 3;

  localparam logic [6:0] CTRL0_RST = 7'h00;
  localparam logic [2:0] FCTL_RST  = 3'h0;
  localparam logic [7:0] TRIG_RST  = 8'h00;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;

  // ---------------------------------------------------------------
  // Frame format
  // ---------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  typedef struct packed {
    logic       msb_first;
    logic       two_stop;
    logic [1:0] parity;
    logic       char7;
  } ufx_frame_cfg_s;

  typedef struct packed {
    logic       ferr;
    logic       perr;
    logic [7:0] data;
  } ufx_rx_word_s;

  typedef enum logic [1:0] {
    UFX_TX_IDLE  = 2'b01,
    UFX_TX_SHIFT = 2'b10
  } ufx_tx_state_e;

  typedef enum logic [2:0] {
    UFX_RX_IDLE  = 3'b001,
    UFX_RX_START = 3'b010,
    UFX_RX_BITS  = 3'b100
  } ufx_rx_state_e;

endpackage

/* File: core/ufx_irq_gate.sv */
`timescale 1ns/10ps
module ufx_irq_gate (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       flush_in,
  input  wire logic       pointer_in,
  input  wire logic [4:0] trig_in,
  input  wire logic       event_in,
  input  wire logic       credit_in,
  output logic            fire_out
);
  logic [4:0] evt_cnt_q, evt_cnt_d;
  logic [4:0] crd_cnt_q, crd_cnt_d;
  logic [3:0] pend_q, pend_d;
  logic       armed_q, armed_d;
  logic       fire_d;
  logic       evt_hit;
  logic       crd_hit;

  always_comb begin
    evt_hit   = event_in && (pointer_in || (evt_cnt_q + 5'h01 == trig_in)); // R15
    crd_hit   = credit_in && (crd_cnt_q + 5'h01 == trig_in);
    evt_cnt_d = evt_cnt_q;
    crd_cnt_d = crd_cnt_q;
    pend_d    = pend_q;
    armed_d   = armed_q;
    fire_d    = 1'b0;
    if (event_in) begin
      evt_cnt_d = evt_hit ? 5'h00 : evt_cnt_q + 5'h01;
    end
    if (credit_in) begin
      crd_cnt_d = crd_hit ? 5'h00 : crd_cnt_q + 5'h01;
    end
    if (pointer_in) begin
      fire_d    = evt_hit; // R1 R5 R17
      armed_d   = 1'b1;
      pend_d    = 4'h0;
      crd_cnt_d = 5'h00;
    end else begin
      if (crd_hit) begin
        if (pend_q != 4'h0) begin
          fire_d = 1'b1; // R16
          pend_d = pend_q - 4'h1;
        end else begin
          armed_d = 1'b1;
        end
      end
      if (evt_hit) begin
        if (armed_d && !fire_d) begin
          fire_d  = 1'b1;
          armed_d = 1'b0;
        end else if (pend_d != 4'hF) begin
          pend_d = pend_d + 4'h1; // R16
        end
      end
    end
    if (flush_in) begin
      evt_cnt_d = 5'h00; // R19
      crd_cnt_d = 5'h00;
      pend_d    = 4'h0;
      armed_d   = 1'b1;
      fire_d    = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_cnt_q <= 5'h00;
      crd_cnt_q <= 5'h00;
      pend_q    <= 4'h0;
      armed_q   <= 1'b1;
      fire_out  <= 1'b0; // R21
    end else begin
      evt_cnt_q <= evt_cnt_d;
      crd_cnt_q <= crd_cnt_d;
      pend_q    <= pend_d;
      armed_q   <= armed_d;
      fire_out  <= fire_d;
    end
  end
endmodule

/* File: dv/ufx_top_asserts.sv */
`timescale 1ns/10ps
module ufx_top_asserts (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [5:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [31:0] rdata_out,
  input  wire logic        serial_in_pin_in,
  input  wire logic        serial_out_pin_out,
  input  wire logic        tx_done_irq_out,
  input  wire logic        rx_done_irq_out,
  input  wire logic        tx_drained_irq_out
);
  // ----
  // Mode snoop
  // ----
  logic [2:0] fctl_q;
  logic [2:0] fctl_d;
  logic       hot;

  always_comb begin
    fctl_d = fctl_q;
    if (wr_in && addr_in == ufx_pkg::A_FCTL) begin
      fctl_d = wdata_in[2:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fctl_q <= ufx_pkg::FCTL_RST;
    end else begin
      fctl_q <= fctl_d;
    end
  end

  // Single mode or pointer policy: every load reports at once
  assign hot = !fctl_q[ufx_pkg::FCTL_SEL] || fctl_q[ufx_pkg::FCTL_TXPOL];

  // ----
  // Properties
  // ----
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_rdata_idle;
    !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_unmapped;
    rd_in && (addr_in[1:0] != 2'h0 || addr_in > ufx_pkg::A_RXFILL) |=> rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");

  property p_free_range;
    rd_in && addr_in == ufx_pkg::A_TXFREE |=> rdata_out <= 32'h10;
  endproperty
  a_free_range: assert property (p_free_range)
    else $error("free count above depth");

  property p_fill_range;
    rd_in && addr_in == ufx_pkg::A_RXFILL |=> rdata_out <= 32'h10;
  endproperty
  a_fill_range: assert property (p_fill_range)
    else $error("fill count above depth");

  // Start bit held one bit period; bench runs with divisor 3
  property p_tx_start;
    tx_done_irq_out && hot |-> $fell(serial_out_pin_out) ##1 !serial_out_pin_out [*3];
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("transmit done without start bit");

  property p_reset_quiet;
    $fell(rst_in) |-> serial_out_pin_out && !tx_done_irq_out && !rx_done_irq_out
      && !tx_drained_irq_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("event or low line after reset");

  property p_drained_idle;
    tx_drained_irq_out |-> serial_out_pin_out && $past(serial_out_pin_out);
  endproperty
  a_drained_idle: assert property (p_drained_idle)
    else $error("drained event while line busy");

  property p_drained_mode;
    tx_drained_irq_out |-> fctl_q[ufx_pkg::FCTL_SEL];
  endproperty
  a_drained_mode: assert property (p_drained_mode)
    else $error("drained event outside fifo mode");

  property p_pause;
    tx_drained_irq_out |=> serial_out_pin_out;
  endproperty
  a_pause: assert property (p_pause)
    else $error("line left idle too early");

  property p_rx_stop;
    rx_done_irq_out |-> $past(serial_in_pin_in, 3);
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("receive done without stop bit");

  c_tx_done: cover property (tx_done_irq_out);
  c_rx_done: cover property (rx_done_irq_out);
  c_drained: cover property (tx_drained_irq_out);
endmodule

bind ufx_top ufx_top_asserts u_chk (
  .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .serial_in_pin_in(serial_in_pin_in), .serial_out_pin_out(serial_out_pin_out),
  .tx_done_irq_out(tx_done_irq_out), .rx_done_irq_out(rx_done_irq_out),
  .tx_drained_irq_out(tx_drained_irq_out)
);

/* File: dv/ufx_remote.sv */
`timescale 1ns/10ps
module ufx_remote #(
  parameter int BIT = 4
) (
  input  wire logic mclk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [8:0] got_q[$];
  int         nbits = 8;
  logic [8:0] w;

  initial line_out = 1'b1;

  // ----
  // Catch frames, sampling mid-bit
  // ----
  always begin
    @(posedge mclk_in iff !line_in);
    repeat (BIT / 2) @(posedge mclk_in);
    w = 9'h000;
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge mclk_in);
      w[i] = line_in;
    end
    repeat (BIT) @(posedge mclk_in);
    if (line_in) begin
      got_q.push_back(w);
    end
  end

  // Start, data LSB first, stop; idle high afterwards
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_in);
      line_out <= f[i];
      repeat (BIT - 1) @(posedge mclk_in);
    end
    @(posedge mclk_in);
  endtask
endmodule

/* File: dv/tb_uart_fifo_tx_rx_interrupt_logic.sv */
`timescale 1ns/10ps
module tb_uart_fifo_tx_rx_interrupt_logic;
  logic        mclk_in;
  logic        rst_in;
  logic [5:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        ser_rx;
  logic        ser_tx;
  logic        txd;
  logic        rxd;
  logic        drn;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_txd = 0;
  int          n_rxd = 0;
  int          n_drn = 0;

  ufx_top dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .serial_in_pin_in(ser_rx),
    .serial_out_pin_out(ser_tx), .tx_done_irq_out(txd), .rx_done_irq_out(rxd),
    .tx_drained_irq_out(drn)
  );

  ufx_remote #(.BIT(4)) rem (.mclk_in(mclk_in), .line_in(ser_tx), .line_out(ser_rx));

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  always @(posedge mclk_in) begin
    if (txd === 1'b1) n_txd++;
    if (rxd === 1'b1) n_rxd++;
    if (drn === 1'b1) n_drn++;
  end

  // ----
  // Tasks
  // ----
  task automatic test_done();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    chk(rdata_out, exp);
  endtask

  // Waits for n caught frames, then lets the frame end settle
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (rem.got_q.size() < n && k < 3000) begin
      @(posedge mclk_in);
      k++;
    end
    chk(rem.got_q.size(), n);
    repeat (20) @(posedge mclk_in);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_mismatch++;
    test_done();
  end

  // ----
  // Sequence
  // ----
  initial begin
    rst_in = 1'b1;
    addr_in = 6'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(ufx_pkg::A_CTRL0, 32'h0);
    rd(ufx_pkg::A_TRIG, 32'h0);
    rd(6'h24, 32'h0);
    wr(ufx_pkg::A_DIV, 32'h3);
    wr(ufx_pkg::A_CTRL0, 32'h3);
    wr(ufx_pkg::A_TXDATA, 32'hA5);
    wait_got(1);
    chk(rem.got_q.pop_front(), 32'hA5);
    wr(ufx_pkg::A_CTRL0, 32'h43);
    wr(ufx_pkg::A_TXDATA, 32'h01);
    wait_got(1);
    chk(rem.got_q.pop_front(), 32'h80);
    rem.nbits = 9;
    wr(ufx_pkg::A_CTRL0, 32'h1B);
    wr(ufx_pkg::A_TXDATA, 32'h07);
    wait_got(1);
    chk(rem.got_q.pop_front(), 32'h107);
    rem.nbits = 8;
    chk(n_txd, 3);
    chk(n_drn, 0);
    wr(ufx_pkg::A_CTRL0, 32'h2);
    wr(ufx_pkg::A_FCTL, 32'h7);
    wr(ufx_pkg::A_TRIG, 32'h0);
    for (int i = 1; i < 4; i++) wr(ufx_pkg::A_TXDATA, 32'h11 * i);
    rd(ufx_pkg::A_TXFREE, 32'hD);
    repeat (40) @(posedge mclk_in);
    chk(rem.got_q.size(), 0);
    wr(ufx_pkg::A_CTRL0, 32'h3);
    wait_got(3);
    for (int i = 1; i < 4; i++) chk(rem.got_q.pop_front(), 32'h11 * i);
    chk(n_txd, 6);
    chk(n_drn, 1);
    chk(ser_tx, 1'b1);
    rd(ufx_pkg::A_TXFREE, 32'h10);
    wr(ufx_pkg::A_CTRL0, 32'h2);
    wr(ufx_pkg::A_FCTL, 32'h1);
    wr(ufx_pkg::A_TRIG, 32'h1);
    for (int i = 0; i < 4; i++) wr(ufx_pkg::A_TXDATA, 32'h41 + i);
    wr(ufx_pkg::A_CTRL0, 32'h3);
    wait_got(4);
    chk(n_txd, 7);
    wr(ufx_pkg::A_CTRL0, 32'h2);
    wr(ufx_pkg::A_TXDATA, 32'h51);
    wr(ufx_pkg::A_TXDATA, 32'h52);
    repeat (5) @(posedge mclk_in);
    chk(n_txd, 8);
    wr(ufx_pkg::A_CTRL0, 32'h3);
    wait_got(6);
    chk(n_txd, 8);
    chk(n_drn, 3);
    rd(ufx_pkg::A_STATUS, 32'h0);
    wr(ufx_pkg::A_CTRL0, 32'h2);
    wr(ufx_pkg::A_FCTL, 32'h9);
    wr(ufx_pkg::A_TXDATA, 32'h61);
    wr(ufx_pkg::A_TXDATA, 32'h62);
    repeat (5) @(posedge mclk_in);
    chk(n_txd, 8);
    wr(ufx_pkg::A_CTRL0, 32'h3);
    wait_got(8);
    chk(n_txd, 9);
    rem.got_q.delete();
    wr(ufx_pkg::A_FCTL, 32'h7);
    wr(ufx_pkg::A_TRIG, 32'h0);
    fork
      begin
        rem.send(8'h3C);
        rem.send(8'hC3);
      end
      wr(ufx_pkg::A_TXDATA, 32'h5A);
    join
    wait_got(1);
    chk(rem.got_q.pop_front(), 32'h5A);
    chk(n_rxd, 2);
    rd(ufx_pkg::A_RXFILL, 32'h2);
    rd(ufx_pkg::A_RXDATA, 32'h3C);
    rd(ufx_pkg::A_RXDATA, 32'hC3);
    rd(ufx_pkg::A_RXFILL, 32'h0);
    // Seven bits, odd parity, two stop bits
    wr(ufx_pkg::A_CTRL0, 32'h37);
    wr(ufx_pkg::A_TXDATA, 32'h55);
    wait_got(1);
    chk(rem.got_q.pop_front(), 32'hD5);
    wr(ufx_pkg::A_TXDATA, 32'h66);
    wr(ufx_pkg::A_TXDATA, 32'h77);
    rd(ufx_pkg::A_STATUS, 32'h1);
    repeat (9) @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (100) @(posedge mclk_in);
    chk(n_txd, 12);
    chk(n_drn, 6);
    chk(ser_tx, 1'b1);
    test_done();
  end
endmodule
